// ### fpu_error_trap_control.sv
// Contract
// - Legacy port access clears numeric interrupt request.
// - Legacy port access sets ignore-error level.
// - Ignore level lets waiting instructions run.
// - Clear-exceptions clears flags, releases error output.
// - Error release resets the ignore flip-flop.
// - Full-state store clears flags after storing.
// - Reload reasserts error; ignore stays clear.
// - Unmasked error traps waiting instruction to handler.
// - Ignore state saved and restored around SYSTEM_MANAGEMENT_MODE.
// - Hardware task switch sets task-switched flag.
// - Software may set flag through register write.
// - Task-switched flag traps fp with vector 7.
// - Clear-task-switched instruction clears the flag.
// - Emulation flag also traps fp instructions.
// - Emulation flag makes multimedia invalid opcode.
// - Device-unavailable precedes numeric error.
`timescale 1ns/100ps
`include "fpu_trap_defines.svh"

module fpu_error_trap_control
    import fpu_trap_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               reset_i,
    fpu_glue_if.cpu                 link,
    input  wire logic               instr_valid_i,
    input  wire op_t                instr_op_i,
    input  wire logic [`FLAG_W-1:0] instr_flags_i,
    input  wire logic [`FLAG_W-1:0] instr_masks_i,
    input  wire logic               hw_task_switch_i,
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic [31:0]        reg_wdata_i,
    input  wire logic               reg_write_i,
    input  wire logic               reg_read_i,
    output logic      [31:0]        reg_rdata_o,
    output logic                    done_o,
    output outcome_t                outcome_o,
    output logic      [7:0]         vector_o,
    output logic      [`FLAG_W-1:0] status_word_o,
    output logic                    irq_o
);

    // ============================================================
    // Architectural state
    // ============================================================
    logic                task_switched_flag;
    logic                no_fpu_present_flag;
    logic [`FLAG_W-1:0]  error_flags;
    logic [`FLAG_W-1:0]  error_masks;
    logic [`EV_W-1:0]    int_status;
    logic [`EV_W-1:0]    int_mask;
    logic                pending_error;
    logic                ignore_active;
    logic                is_fp;
    logic                is_waiting;
    logic                execute;
    logic                cr0_write;
    outcome_t            next_outcome;
    logic [7:0]          next_vector;
    logic [`EV_W-1:0]    events;

    assign cr0_write     = reg_write_i && (reg_addr_i == `CR0_OFS);
    assign pending_error = |(error_flags & ~error_masks);
    assign ignore_active = ~link.ignore_numeric_error_n;

    // ============================================================
    // Instruction classification
    // ============================================================
    always_comb
    begin
        is_fp      = 1'b0;
        is_waiting = 1'b0;
        unique case (instr_op_i)
            OP_FP_ARITH, OP_CLEAR_EXC, OP_FULL_RELOAD, OP_LOAD_CW:
            begin
                is_fp      = 1'b1;
                is_waiting = 1'b1;
            end
            OP_FULL_STORE, OP_STORE_SW_NOWAIT:
            begin
                is_fp      = 1'b1;
                is_waiting = 1'b0;
            end
            OP_NONE, OP_CLEAR_TS, OP_MULTIMEDIA, OP_INTEGER:
            begin
                is_fp      = 1'b0;
                is_waiting = 1'b0;
            end
            default:
            begin
                is_fp      = 1'b0;
                is_waiting = 1'b0;
            end
        endcase
    end

    // ============================================================
    // Exception decision
    // ============================================================
    // Availability checks come first so a numeric error is handled
    // later in the context that owns it.
    always_comb
    begin
        next_outcome = OUT_EXECUTED;
        next_vector  = `VEC_NONE;
        if (instr_op_i == OP_MULTIMEDIA)
        begin
            if (no_fpu_present_flag)
            begin
                next_outcome = OUT_INVALID_OP;
                next_vector  = `VEC_UD;
            end
            else if (task_switched_flag)
            begin
                next_outcome = OUT_DEV_UNAVAIL;
                next_vector  = `VEC_DNA;
            end
        end
        else if (is_fp)
        begin
            if (task_switched_flag || no_fpu_present_flag)
            begin
                next_outcome = OUT_DEV_UNAVAIL;
                next_vector  = `VEC_DNA;
            end
            else if (is_waiting && pending_error && !ignore_active)
            begin
                next_outcome = OUT_NUMERIC_ERR;
                next_vector  = `VEC_MF;
            end
        end
    end

    assign execute = instr_valid_i && (next_outcome == OUT_EXECUTED);

    always_comb
    begin
        events                = '0;
        events[`EV_DNA_BIT]   = instr_valid_i &&
                                (next_outcome == OUT_DEV_UNAVAIL);
        events[`EV_UD_BIT]    = instr_valid_i &&
                                (next_outcome == OUT_INVALID_OP);
        events[`EV_MF_BIT]    = instr_valid_i &&
                                (next_outcome == OUT_NUMERIC_ERR);
    end

    // ============================================================
    // Control register zero
    // ============================================================
    // A hardware task switch wins over a clear in the same cycle.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            task_switched_flag  <= 1'b0;
            no_fpu_present_flag <= 1'b0;
        end
        else
        begin
            if (cr0_write)
            begin
                task_switched_flag  <= reg_wdata_i[`TS_BIT];
                no_fpu_present_flag <= reg_wdata_i[`EM_BIT];
            end
            if (instr_valid_i && instr_op_i == OP_CLEAR_TS)
                task_switched_flag <= 1'b0;
            if (hw_task_switch_i)
                task_switched_flag <= 1'b1;
        end
    end

    // ============================================================
    // Floating-point error flags and masks
    // ============================================================
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            error_flags <= `FLAGS_RST;
            error_masks <= `MASKS_RST;
        end
        else if (execute)
        begin
            unique case (instr_op_i)
                OP_FP_ARITH:
                    error_flags <= error_flags | instr_flags_i;
                OP_CLEAR_EXC:
                    error_flags <= `FLAGS_RST;
                OP_FULL_STORE:
                begin
                    error_flags <= `FLAGS_RST;
                    error_masks <= `MASKS_RST;
                end
                OP_FULL_RELOAD:
                begin
                    error_flags <= instr_flags_i;
                    error_masks <= instr_masks_i;
                end
                OP_LOAD_CW:
                    error_masks <= instr_masks_i;
                OP_NONE, OP_STORE_SW_NOWAIT, OP_CLEAR_TS,
                OP_MULTIMEDIA, OP_INTEGER:
                    error_flags <= error_flags;
                default:
                    error_flags <= error_flags;
            endcase
        end
    end

    // Error output is low while any unmasked flag is pending.
    assign link.fp_error_out_n = ~pending_error;

    // ============================================================
    // Instruction result
    // ============================================================
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            done_o        <= 1'b0;
            outcome_o     <= OUT_EXECUTED;
            vector_o      <= `VEC_NONE;
            status_word_o <= `FLAGS_RST;
        end
        else
        begin
            done_o    <= instr_valid_i;
            outcome_o <= next_outcome;
            vector_o  <= next_vector;
            if (execute && (instr_op_i == OP_STORE_SW_NOWAIT ||
                            instr_op_i == OP_FULL_STORE))
                status_word_o <= error_flags;
        end
    end

    // ============================================================
    // Interrupt status and mask
    // ============================================================
    // A new event wins over the clear made by a read.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            int_status <= '0;
        else if (reg_read_i && reg_addr_i == `INT_STATUS_OFS)
            int_status <= events;
        else
            int_status <= int_status | events;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            int_mask <= `INT_MASK_RST;
        else if (reg_write_i && reg_addr_i == `INT_MASK_OFS)
            int_mask <= reg_wdata_i[`EV_W-1:0];
    end

    assign irq_o = |(int_status & int_mask);

    // ============================================================
    // Register read port
    // ============================================================
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            reg_rdata_o <= 32'h0000_0000;
        else if (reg_read_i)
        begin
            reg_rdata_o <= 32'h0000_0000;
            unique case (reg_addr_i)
                `CR0_OFS:
                begin
                    reg_rdata_o[`TS_BIT] <= task_switched_flag;
                    reg_rdata_o[`EM_BIT] <= no_fpu_present_flag;
                end
                `FP_STATUS_OFS:
                    reg_rdata_o[`FLAG_W-1:0] <= error_flags;
                `FP_CONTROL_OFS:
                    reg_rdata_o[`FLAG_W-1:0] <= error_masks;
                `INT_STATUS_OFS:
                    reg_rdata_o[`EV_W-1:0] <= int_status;
                `INT_MASK_OFS:
                    reg_rdata_o[`EV_W-1:0] <= int_mask;
                default:
                    reg_rdata_o <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// ### fpu_trap_defines.svh
`ifndef FPU_TRAP_DEFINES_SVH
`define FPU_TRAP_DEFINES_SVH

// ============================================================
// Register offsets of the processor-side register port
// ============================================================
`define CR0_OFS          8'h00
`define FP_STATUS_OFS    8'h04
`define FP_CONTROL_OFS   8'h08
`define INT_STATUS_OFS   8'h0C
`define INT_MASK_OFS     8'h10

// ============================================================
// Field positions and widths
// ============================================================
`define TS_BIT           3
`define EM_BIT           2
`define FLAG_W           6
`define EV_DNA_BIT       0
`define EV_UD_BIT        1
`define EV_MF_BIT        2
`define EV_W             3

// ============================================================
// Reset values
// ============================================================
`define FLAGS_RST        6'h00
`define MASKS_RST        6'h3F
`define INT_MASK_RST     3'h0

// ============================================================
// Exception vectors
// ============================================================
`define VEC_NONE         8'h00
`define VEC_UD           8'h06
`define VEC_DNA          8'h07
`define VEC_MF           8'h10

// ============================================================
// Legacy coprocessor I/O port
// ============================================================
`define LEGACY_PORT      16'h00F0

`endif

// ### fpu_trap_pkg.sv
package fpu_trap_pkg;

    // ============================================================
    // Instruction classes presented on the issue port
    // ============================================================
    typedef enum logic [3:0]
    {
        OP_NONE,
        OP_FP_ARITH,
        OP_CLEAR_EXC,
        OP_FULL_STORE,
        OP_FULL_RELOAD,
        OP_LOAD_CW,
        OP_STORE_SW_NOWAIT,
        OP_CLEAR_TS,
        OP_MULTIMEDIA,
        OP_INTEGER
    } op_t;

    // ============================================================
    // Outcome of one issued instruction
    // ============================================================
    typedef enum logic [1:0]
    {
        OUT_EXECUTED,
        OUT_DEV_UNAVAIL,
        OUT_INVALID_OP,
        OUT_NUMERIC_ERR
    } outcome_t;

endpackage

// ### fpu_glue_if.sv
`timescale 1ns/100ps

interface fpu_glue_if;
    logic fp_error_out_n;
    logic ignore_numeric_error_n;

    modport cpu
    (
        output fp_error_out_n,
        input  ignore_numeric_error_n
    );

    modport glue
    (
        input  fp_error_out_n,
        output ignore_numeric_error_n
    );
endinterface

// ### fpu_glue_logic.sv
`timescale 1ns/100ps
`include "fpu_trap_defines.svh"

module fpu_glue_logic
    import fpu_trap_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    fpu_glue_if.glue         link,
    input  wire logic        io_write_i,
    input  wire logic [15:0] io_addr_i,
    input  wire logic        smm_restore_i,
    input  wire logic        smm_restore_value_i,
    output logic             numeric_irq_request_o,
    output logic             ignore_state_o
);

    // ============================================================
    // Error edge detection and port decode
    // ============================================================
    logic prev_error_n;
    logic irq_ff;
    logic ignore_ff;
    logic error_edge;
    logic port_hit;

    assign error_edge = prev_error_n & ~link.fp_error_out_n;
    assign port_hit   = io_write_i && (io_addr_i == `LEGACY_PORT);

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            prev_error_n <= 1'b1;
        else
            prev_error_n <= link.fp_error_out_n;
    end

    // ============================================================
    // First flip-flop: numeric interrupt request
    // ============================================================
    // A new error assertion wins over a port access in the same cycle.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            irq_ff <= 1'b0;
        else if (error_edge)
            irq_ff <= 1'b1;
        else if (port_hit)
            irq_ff <= 1'b0;
    end

    // ============================================================
    // Second flip-flop: ignore-numeric-error level
    // ============================================================
    // Only the port access or an SMM restore sets it, so a reloaded error does not.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            ignore_ff <= 1'b0;
        else if (link.fp_error_out_n)
            ignore_ff <= 1'b0;
        else if (smm_restore_i)
            ignore_ff <= smm_restore_value_i;
        else if (port_hit)
            ignore_ff <= 1'b1;
    end

    assign link.ignore_numeric_error_n = ~ignore_ff;
    assign numeric_irq_request_o       = irq_ff;
    assign ignore_state_o              = ignore_ff;

endmodule

// ### fpu_trap_monitor.sv
`timescale 1ns/100ps
`include "fpu_trap_defines.svh"

module fpu_trap_monitor
    import fpu_trap_pkg::*;
(
    input logic        clk_i,
    input logic        reset_i,
    input logic        fp_error_out_n,
    input logic        ignore_numeric_error_n,
    input logic        io_write_i,
    input logic [15:0] io_addr_i,
    input logic        smm_restore_i,
    input logic        numeric_irq_request_o,
    input logic        hw_task_switch_i,
    input logic        instr_valid_i,
    input op_t         instr_op_i,
    input outcome_t    outcome_o,
    input logic [7:0]  vector_o,
    input logic        done_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    logic hit;
    logic ldcw;
    assign hit = io_write_i && (io_addr_i == `LEGACY_PORT);
    assign ldcw = instr_valid_i && (instr_op_i == OP_LOAD_CW);

    // ============================================================
    // Glue circuit
    // ============================================================
    a_error_sets_irq: assert property ($fell(fp_error_out_n)
        |=> numeric_irq_request_o) else $error("irq not raised");
    a_port_clears_irq: assert property (hit && !$fell(fp_error_out_n)
        |=> !numeric_irq_request_o) else $error("irq not cleared");
    a_port_sets_ignore: assert property (hit && !fp_error_out_n
        && !smm_restore_i |=> !ignore_numeric_error_n)
        else $error("ignore not set");
    a_release_ignore: assert property (fp_error_out_n
        |=> ignore_numeric_error_n) else $error("ignore not released");
    a_reload_no_ignore: assert property (ignore_numeric_error_n
        && !hit && !smm_restore_i |=> ignore_numeric_error_n)
        else $error("ignore set without port");

    // ============================================================
    // Instruction outcomes
    // ============================================================
    a_ignore_runs: assert property (instr_valid_i
        && !ignore_numeric_error_n |=> outcome_o != OUT_NUMERIC_ERR)
        else $error("trap while ignoring");
    a_wait_traps: assert property (ldcw && !fp_error_out_n
        && ignore_numeric_error_n
        |=> outcome_o inside {OUT_NUMERIC_ERR, OUT_DEV_UNAVAIL})
        else $error("pending error not trapped");
    a_nowait_runs: assert property (instr_valid_i
        && instr_op_i == OP_FULL_STORE |=> outcome_o != OUT_NUMERIC_ERR)
        else $error("no-wait store trapped");
    a_switch_traps: assert property (hw_task_switch_i ##1
        (instr_valid_i && instr_op_i == OP_FP_ARITH)
        |=> outcome_o == OUT_DEV_UNAVAIL) else $error("no trap after switch");
    a_dna_vector: assert property (done_o
        && outcome_o == OUT_DEV_UNAVAIL |-> vector_o == `VEC_DNA)
        else $error("wrong vector");

    c_dna: cover property (done_o && outcome_o == OUT_DEV_UNAVAIL);
    c_numeric: cover property (done_o && outcome_o == OUT_NUMERIC_ERR);
    c_port: cover property (hit ##1 !ignore_numeric_error_n);
endmodule

// ### tb_top.sv
`timescale 1ns/100ps

module tb_top
    import fpu_trap_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        instr_valid_i = 1'b0;
    op_t         instr_op_i = OP_NONE;
    logic [5:0]  instr_flags_i = 6'h00;
    logic [5:0]  instr_masks_i = 6'h00;
    logic        hw_task_switch_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_write_i = 1'b0;
    logic        reg_read_i = 1'b0;
    logic        io_write_i = 1'b0;
    logic [15:0] io_addr_i = 16'h0000;
    logic        smm_restore_i = 1'b0;
    logic        smm_restore_value_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic        done_o;
    outcome_t    outcome_o;
    logic [7:0]  vector_o;
    logic [5:0]  status_word_o;
    logic        irq_o;
    logic        numeric_irq_request_o;
    logic        ignore_state_o;
    logic [31:0] v;
    int          error_cnt = 0;
    int          n_tests = 0;

    always #5 clk_i = ~clk_i;

    fpu_glue_if link();

    fpu_error_trap_control i_fpu_error_trap_control
    (
        .clk_i, .reset_i, .link(link), .instr_valid_i, .instr_op_i,
        .instr_flags_i, .instr_masks_i, .hw_task_switch_i, .reg_addr_i,
        .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .done_o,
        .outcome_o, .vector_o, .status_word_o, .irq_o
    );

    fpu_glue_logic i_fpu_glue_logic
    (
        .clk_i, .reset_i, .link(link), .io_write_i, .io_addr_i,
        .smm_restore_i, .smm_restore_value_i, .numeric_irq_request_o,
        .ignore_state_o
    );

    fpu_trap_monitor i_fpu_trap_monitor
    (
        .clk_i, .reset_i, .fp_error_out_n(link.fp_error_out_n),
        .ignore_numeric_error_n(link.ignore_numeric_error_n), .io_write_i,
        .io_addr_i, .smm_restore_i, .numeric_irq_request_o,
        .hw_task_switch_i, .instr_valid_i, .instr_op_i, .outcome_o,
        .vector_o, .done_o
    );

    // ============================================================
    // Shared tasks
    // ============================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    task automatic issue(input op_t op, input logic [5:0] f, m,
                         input outcome_t eo, input logic [7:0] ev);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        hw_task_switch_i <= 1'b0;
        instr_op_i <= op;
        instr_flags_i <= f;
        instr_masks_i <= m;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        #1;
        chk(done_o, 1);
        chk(outcome_o, eo);
        chk(vector_o, ev);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_write_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        reg_read_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1;
        v = reg_rdata_o;
    endtask

    // Drives either the port write or the restore strobe for one cycle.
    task automatic glue(input logic w, r, rv, input logic [15:0] a);
        @(posedge clk_i);
        io_write_i <= w;
        io_addr_i <= a;
        smm_restore_i <= r;
        smm_restore_value_i <= rv;
        @(posedge clk_i);
        io_write_i <= 1'b0;
        smm_restore_i <= 1'b0;
        #1;
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ============================================================
    // Scenarios
    // ============================================================
    task automatic t_glue();
        chk(numeric_irq_request_o, 0);
        chk(ignore_state_o, 0);
        wr(8'h10, 32'h7);
        issue(OP_LOAD_CW, 6'h00, 6'h00, OUT_EXECUTED, 8'h00);
        issue(OP_FP_ARITH, 6'h01, 6'h00, OUT_EXECUTED, 8'h00);
        tick();
        chk(link.fp_error_out_n, 0);
        chk(numeric_irq_request_o, 1);
        glue(1'b1, 1'b0, 1'b0, 16'h00F1);
        chk(numeric_irq_request_o, 1);
        chk(link.ignore_numeric_error_n, 1);
        glue(1'b1, 1'b0, 1'b0, 16'h00F0);
        chk(numeric_irq_request_o, 0);
        chk(link.ignore_numeric_error_n, 0);
        issue(OP_LOAD_CW, 6'h00, 6'h00, OUT_EXECUTED, 8'h00);
        issue(OP_CLEAR_EXC, 6'h00, 6'h00, OUT_EXECUTED, 8'h00);
        chk(link.fp_error_out_n, 1);
        tick();
        chk(link.ignore_numeric_error_n, 1);
        chk(irq_o, 0);
    endtask

    task automatic t_swap();
        issue(OP_FP_ARITH, 6'h01, 6'h00, OUT_EXECUTED, 8'h00);
        tick();
        glue(1'b1, 1'b0, 1'b0, 16'h00F0);
        chk(ignore_state_o, 1);
        issue(OP_FULL_STORE, 6'h00, 6'h00, OUT_EXECUTED, 8'h00);
        chk(status_word_o, 6'h01);
        chk(link.fp_error_out_n, 1);
        tick();
        chk(link.ignore_numeric_error_n, 1);
        issue(OP_FULL_RELOAD, 6'h01, 6'h00, OUT_EXECUTED, 8'h00);
        chk(link.fp_error_out_n, 0);
        tick();
        chk(link.ignore_numeric_error_n, 1);
        chk(numeric_irq_request_o, 1);
        issue(OP_LOAD_CW, 6'h00, 6'h00, OUT_NUMERIC_ERR, 8'h10);
        chk(irq_o, 1);
        rd(8'h0C);
        chk(v, 32'h4);
        chk(irq_o, 0);
        glue(1'b0, 1'b1, 1'b1, 16'h0000);
        chk(link.ignore_numeric_error_n, 0);
        issue(OP_LOAD_CW, 6'h00, 6'h00, OUT_EXECUTED, 8'h00);
        issue(OP_CLEAR_EXC, 6'h00, 6'h00, OUT_EXECUTED, 8'h00);
        tick();
    endtask

    task automatic t_switch();
        issue(OP_FP_ARITH, 6'h02, 6'h00, OUT_EXECUTED, 8'h00);
        @(posedge clk_i);
        hw_task_switch_i <= 1'b1;
        issue(OP_FP_ARITH, 6'h00, 6'h00, OUT_DEV_UNAVAIL, 8'h07);
        rd(8'h00);
        chk(v, 32'h8);
        rd(8'h0C);
        chk(v, 32'h1);
        issue(OP_CLEAR_TS, 6'h00, 6'h00, OUT_EXECUTED, 8'h00);
        rd(8'h00);
        chk(v, 32'h0);
        issue(OP_FP_ARITH, 6'h00, 6'h00, OUT_NUMERIC_ERR, 8'h10);
        issue(OP_STORE_SW_NOWAIT, 6'h00, 6'h00, OUT_EXECUTED, 8'h00);
        chk(status_word_o, 6'h02);
        issue(OP_FULL_STORE, 6'h00, 6'h00, OUT_EXECUTED, 8'h00);
        wr(8'h00, 32'h8);
        issue(OP_LOAD_CW, 6'h00, 6'h00, OUT_DEV_UNAVAIL, 8'h07);
        wr(8'h00, 32'h4);
        issue(OP_FP_ARITH, 6'h00, 6'h00, OUT_DEV_UNAVAIL, 8'h07);
        issue(OP_MULTIMEDIA, 6'h00, 6'h00, OUT_INVALID_OP, 8'h06);
        issue(OP_INTEGER, 6'h00, 6'h00, OUT_EXECUTED, 8'h00);
        rd(8'h0C);
        chk(v, 32'h7);
        wr(8'h10, 32'h0);
        issue(OP_FP_ARITH, 6'h00, 6'h00, OUT_DEV_UNAVAIL, 8'h07);
        chk(irq_o, 0);
        rd(8'h0C);
        chk(v, 32'h1);
        rd(8'h20);
        chk(v, 32'h0);
        wr(8'h04, 32'h3F);
        rd(8'h04);
        chk(v, 32'h0);
        rd(8'h08);
        chk(v, 32'h3F);
        rd(8'h10);
        chk(v, 32'h0);
        wr(8'h00, 32'h0);
    endtask

    // Reset in mid-run with the error line low and the ignore level set.
    task automatic t_reset();
        issue(OP_LOAD_CW, 6'h00, 6'h00, OUT_EXECUTED, 8'h00);
        issue(OP_FP_ARITH, 6'h01, 6'h00, OUT_EXECUTED, 8'h00);
        tick();
        glue(1'b0, 1'b1, 1'b1, 16'h0000);
        chk(numeric_irq_request_o, 1);
        chk(ignore_state_o, 1);
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        chk(numeric_irq_request_o, 0);
        chk(ignore_state_o, 0);
        chk(link.fp_error_out_n, 1);
        issue(OP_FP_ARITH, 6'h01, 6'h00, OUT_EXECUTED, 8'h00);
        chk(link.fp_error_out_n, 1);
    endtask

    initial
    begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        tick();
        t_glue();
        t_swap();
        t_switch();
        t_reset();
        give_verdict();
    end

    initial
    begin
        #100000;
        error_cnt++;
        give_verdict();
    end
endmodule
